// >>> include/pocts_pkg.sv
// Package for the power-on confidence test sequencer: test codes, timing, states.
// Assumes a 100 MHz system clock; all users import the whole package.
package pocts_pkg;

  // Clock rate and derived timing
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned HOLD_TIME_S      = 3;
  localparam int unsigned HOLD_CYCLES      = HOLD_TIME_S * CLK_HZ;
  localparam int unsigned SEQ_TIME_S       = 12;
  localparam int unsigned RAM_TIME_S       = 6;
  localparam int unsigned SIGNON_TIME_MS   = 500;
  localparam int unsigned SIGNON_CYCLES    = SIGNON_TIME_MS * (CLK_HZ / 1000);

  // Widths
  localparam int unsigned CODE_W  = 8;
  localparam int unsigned CNT_W   = 32;
  localparam int unsigned NSTEPS  = 11;
  localparam int unsigned IDX_W   = 4;
  localparam int unsigned SUBN_W  = 4;

  // Result encoding of a test step
  localparam logic [1:0] RES_PASS     = 2'h0;
  localparam logic [1:0] RES_NONFATAL = 2'h1;
  localparam logic [1:0] RES_FATAL    = 2'h2;

  // Test group base codes, ascending
  localparam logic [CODE_W-1:0] CODE_CPU      = 8'h10;
  localparam logic [CODE_W-1:0] CODE_CMOS     = 8'h30;
  localparam logic [CODE_W-1:0] CODE_PROG     = 8'h40;
  localparam logic [CODE_W-1:0] CODE_CPUIO    = 8'h50;
  localparam logic [CODE_W-1:0] CODE_DRAM     = 8'h60;
  localparam logic [CODE_W-1:0] CODE_GPIB     = 8'h70;
  localparam logic [CODE_W-1:0] CODE_KEYPAD   = 8'h82;
  localparam logic [CODE_W-1:0] CODE_ANALOG   = 8'hA0;
  localparam logic [CODE_W-1:0] CODE_DRIVE    = 8'hB0;
  localparam logic [CODE_W-1:0] CODE_CHECKSUM = 8'hD0;
  localparam logic [CODE_W-1:0] CODE_NONE     = 8'h00;
  localparam logic [3:0]        LOW_MASK      = 4'hF;

  // Sequencer states
  typedef enum logic [2:0] {
    POCTS_IDLE,
    POCTS_START,
    POCTS_WAIT,
    POCTS_HOLD,
    POCTS_SIGNON,
    POCTS_READY,
    POCTS_HALT
  } pocts_state_type;

endpackage : pocts_pkg

// >>> hw/pocts_timer.sv
// Down-counting cycle timer used for the error hold and sign-on phases.
// Assumes load and the count are synchronous to sys_clk.
module pocts_timer
  import pocts_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOAD_VALUE = 32'h0000_0001
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Control
  input  wire logic load,
  // Status
  output logic      expired
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // Reload on request, else count down to zero and stay
  assign next_count = load ? LOAD_VALUE : ((count != '0) ? count - 1'b1 : count);
  assign expired    = (count == '0) && !load;

  // Counter register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule : pocts_timer

// >>> hw/pocts_sequencer.sv
// Power-on confidence test sequencer: steps the test groups, shows codes, handles errors.
// Assumes each test engine answers a start pulse with one done pulse and a result.
module pocts_sequencer
  import pocts_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD_LEN   = CNT_W'(HOLD_CYCLES),
  parameter logic [CNT_W-1:0] SIGNON_LEN = CNT_W'(SIGNON_CYCLES)
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Installed option sub-test counts per group (0 = group absent)
  input  wire logic [NSTEPS*SUBN_W-1:0] subCount,
  // Test engine handshake
  output logic                    testStart,
  output logic [CODE_W-1:0]       testCode,
  input  wire logic               testDone,
  input  wire logic [1:0]         testResult,
  // Display
  output logic [CODE_W-1:0]       displayCode,
  output logic                    errorShow,
  output logic [CODE_W-1:0]       errorCode,
  output logic                    errorFatal,
  output logic                    signOn,
  // Rear panel and system
  output logic                    readyLight,
  output logic                    normalRun,
  output logic                    halted
);

  pocts_state_type state;
  pocts_state_type next_state;
  logic [IDX_W-1:0]  stepIdx;
  logic [SUBN_W-1:0] subIdx;
  logic [CODE_W-1:0] curCode;
  logic [SUBN_W-1:0] curCount;
  logic              lastSub;
  logic              lastStep;
  logic              holdLoad;
  logic              holdDone;
  logic              signLoad;
  logic              signDone;
  logic              doneNonfatal;
  logic              doneFatal;
  logic              advance;
  logic [CODE_W-1:0] baseCode;

  // Group code table in ascending order; CMOS sits before program memory
  always_comb begin
    case (stepIdx)
      4'h0:    baseCode = CODE_CPU;
      4'h1:    baseCode = CODE_CMOS;
      4'h2:    baseCode = CODE_PROG;
      4'h3:    baseCode = CODE_CPUIO;
      4'h4:    baseCode = CODE_DRAM;
      4'h5:    baseCode = CODE_GPIB;
      4'h6:    baseCode = CODE_KEYPAD;
      4'h7:    baseCode = CODE_ANALOG;
      4'h8:    baseCode = CODE_DRIVE;
      4'h9:    baseCode = CODE_CHECKSUM;
      default: baseCode = CODE_NONE;
    endcase
  end

  // Sub-test count per group comes from installed options, so length varies
  assign curCount = subCount[stepIdx*SUBN_W +: SUBN_W];
  // Sub-tests count up from the group's own code; adding keeps 82, 83.. ascending
  assign curCode  = baseCode + CODE_W'(subIdx & LOW_MASK);
  assign lastSub  = (subIdx + 1'b1 >= curCount);
  assign lastStep = (stepIdx == IDX_W'(NSTEPS - 2));
  assign doneFatal    = testDone && (testResult == RES_FATAL);
  assign doneNonfatal = testDone && (testResult == RES_NONFATAL);
  assign advance  = (state == POCTS_WAIT && testDone && testResult == RES_PASS)
                 || (state == POCTS_HOLD && holdDone);
  assign holdLoad = (state == POCTS_WAIT) && doneNonfatal;
  assign signLoad = (state == POCTS_START) && (curCount == '0) && lastStep;

  // Error hold timer, three seconds
  pocts_timer #(.LOAD_VALUE(HOLD_LEN)) uHold (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (holdLoad),
    .expired (holdDone)
  );

  // Sign-on message timer
  pocts_timer #(.LOAD_VALUE(SIGNON_LEN)) uSign (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (signLoad || (advance && lastSub && lastStep)),
    .expired (signDone)
  );

  // Next-state decode
  always_comb begin
    next_state = state;
    case (state)
      POCTS_IDLE:   next_state = POCTS_START;
      POCTS_START: begin
        if (curCount == '0) begin
          next_state = lastStep ? POCTS_SIGNON : POCTS_START;
        end else begin
          next_state = POCTS_WAIT;
        end
      end
      POCTS_WAIT: begin
        if (doneFatal) begin
          next_state = POCTS_HALT;
        end else if (doneNonfatal) begin
          next_state = POCTS_HOLD;
        end else if (advance) begin
          next_state = (lastSub && lastStep) ? POCTS_SIGNON : POCTS_START;
        end
      end
      POCTS_HOLD: begin
        if (holdDone) begin
          next_state = (lastSub && lastStep) ? POCTS_SIGNON : POCTS_START;
        end
      end
      POCTS_SIGNON: next_state = signDone ? POCTS_READY : POCTS_SIGNON;
      POCTS_READY:  next_state = POCTS_READY;
      POCTS_HALT:   next_state = POCTS_HALT;
      default:      next_state = POCTS_IDLE;
    endcase
  end

  // State register; reset always reenters the full sequence
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= POCTS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Step and sub-test indices; absent groups are skipped in START
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stepIdx <= '0;
      subIdx  <= '0;
    end else if ((state == POCTS_START && curCount == '0 && !lastStep)
              || (advance && lastSub && !lastStep)) begin
      stepIdx <= stepIdx + 1'b1;
      subIdx  <= '0;
    end else if (advance && !lastSub) begin
      subIdx  <= subIdx + 1'b1;
    end
  end

  // Start pulse and code toward the test engines
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      testStart <= 1'b0;
      testCode  <= CODE_NONE;
    end else begin
      testStart <= (state == POCTS_START) && (curCount != '0);
      testCode  <= curCode;
    end
  end

  // Code shown at lower right, refreshed as each test begins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      displayCode <= CODE_NONE;
    end else if (state == POCTS_START && curCount != '0) begin
      displayCode <= curCode;
    end
  end

  // Bottom-line error message; cleared once the hold ends
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      errorShow  <= 1'b0;
      errorCode  <= CODE_NONE;
      errorFatal <= 1'b0;
    end else if (state == POCTS_WAIT && (doneFatal || doneNonfatal)) begin
      errorShow  <= 1'b1;
      errorCode  <= curCode;
      errorFatal <= doneFatal;
    end else if (state == POCTS_HOLD && holdDone) begin
      errorShow  <= 1'b0;
    end
  end

  // Final status outputs; ready only after sign-on completes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      signOn     <= 1'b0;
      readyLight <= 1'b0;
      normalRun  <= 1'b0;
      halted     <= 1'b0;
    end else begin
      signOn     <= (next_state == POCTS_SIGNON);
      readyLight <= (next_state == POCTS_READY);
      normalRun  <= (next_state == POCTS_READY);
      halted     <= (next_state == POCTS_HALT);
    end
  end

  // Checks
  logic [CODE_W-1:0] prevCode;
  logic              prevValid;

  // Last started code, so ordering is judged against real history
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevCode  <= CODE_NONE;
      prevValid <= 1'b0;
    end else if (testStart) begin
      prevCode  <= testCode;
      prevValid <= 1'b1;
    end
  end

  sequence s_fatal_seen;
    state == POCTS_WAIT && doneFatal;
  endsequence

  a_fatal_halt: assert property (@(posedge sys_clk) disable iff (rst)
    s_fatal_seen |=> (halted && !readyLight)[*4]) else $error("fatal did not halt");
  a_halt_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    halted |=> halted && !readyLight && !testStart) else $error("halt left");
  a_nonfatal_hold: assert property (@(posedge sys_clk) disable iff (rst)
    holdLoad |=> state == POCTS_HOLD && errorShow) else $error("no hold");
  a_hold_shown: assert property (@(posedge sys_clk) disable iff (rst)
    state == POCTS_HOLD && !holdDone |-> errorShow) else $error("hold not shown");
  a_error_posted: assert property (@(posedge sys_clk) disable iff (rst)
    state == POCTS_WAIT && (doneFatal || doneNonfatal)
    |=> errorShow && errorCode == $past(curCode)) else $error("error not posted");
  a_code_shown: assert property (@(posedge sys_clk) disable iff (rst)
    testStart |-> displayCode == testCode) else $error("code not shown");
  a_ready_after: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(readyLight) |-> $past(signOn)) else $error("ready without sign-on");
  a_auto_start: assert property (@(posedge sys_clk)
    $fell(rst) |-> state == POCTS_IDLE ##1 state == POCTS_START) else $error("no auto start");
  a_ascending: assert property (@(posedge sys_clk) disable iff (rst)
    testStart && prevValid |-> testCode > prevCode) else $error("order");
  a_cmos_code: assert property (@(posedge sys_clk) disable iff (rst)
    state == POCTS_START && stepIdx == 4'h1 && subIdx == '0 |-> curCode == CODE_CMOS)
    else $error("cmos code");
  a_keypad_code: assert property (@(posedge sys_clk) disable iff (rst)
    state == POCTS_START && stepIdx == 4'h6 && subIdx == '0 |-> curCode == CODE_KEYPAD)
    else $error("keypad code");

endmodule : pocts_sequencer

// >>> test/pocts_engine_model.sv
// Test engine stand-in: answers each testStart with one testDone pulse.
// Assumes a sync reset; fails only the code the bench names.
module pocts_engine_model
  import pocts_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Request side
  input  wire logic              testStart,
  input  wire logic [CODE_W-1:0] testCode,
  // Fault plan from the bench
  input  wire logic [CODE_W-1:0] failCode,
  input  wire logic [1:0]        failKind,
  // Answer side
  output logic                   testDone = 1'b0,
  output logic [1:0]             testResult = 2'h0
);
  int   waitN = 0;
  logic busy  = 1'b0;
  wire  fin   = busy && (waitN == 1);
  // Random latency 1..4 cycles; result toggles when not valid
  always @(posedge sys_clk) begin
    testDone   <= fin && !rst;
    testResult <= fin ? ((testCode === failCode) ? failKind : RES_PASS) : ~testResult;
    if (rst || fin) begin
      busy <= 1'b0;
    end else if (testStart === 1'b1) begin
      busy  <= 1'b1;
      waitN <= $urandom_range(1, 4);
    end else if (busy) begin
      waitN <= waitN - 1;
    end
  end
endmodule : pocts_engine_model

// >>> test/test_power_on_confidence_test_sequencer.sv
// Bench for the confidence test sequencer: pass, nonfatal and fatal runs.
// Assumes shortened hold and sign-on lengths; codes are checked from a queue.
module test_power_on_confidence_test_sequencer
  import pocts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  localparam logic [CODE_W-1:0] BASES [10] = '{CODE_CPU, CODE_CMOS, CODE_PROG, CODE_CPUIO,
    CODE_DRAM, CODE_GPIB, CODE_KEYPAD, CODE_ANALOG, CODE_DRIVE, CODE_CHECKSUM};
  logic                      sys_clk  = 1'b0;
  logic                      rst      = 1'b1;
  logic [NSTEPS*SUBN_W-1:0]  subCount = '0;
  logic [CODE_W-1:0]         failCode = 8'hFF;
  logic [1:0]                failKind = RES_PASS;
  logic                      testStart, testDone, errorShow, errorFatal, signOn;
  logic                      readyLight, normalRun, halted, sawSignOn;
  logic [1:0]                testResult;
  logic [CODE_W-1:0]         testCode, displayCode, errorCode, lastCode;
  logic [CODE_W-1:0]         expQ [$];
  int                        error_cnt = 0;
  int                        n_checks = 0;
  logic [NSTEPS*SUBN_W-1:0]  sc;
  int                        cnt;
  always #5 sys_clk = ~sys_clk;
  pocts_sequencer #(.HOLD_LEN(32'h0000_0014), .SIGNON_LEN(32'h0000_000A)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .subCount(subCount), .testStart(testStart),
    .testCode(testCode), .testDone(testDone), .testResult(testResult),
    .displayCode(displayCode), .errorShow(errorShow), .errorCode(errorCode),
    .errorFatal(errorFatal), .signOn(signOn), .readyLight(readyLight),
    .normalRun(normalRun), .halted(halted));
  pocts_engine_model i_eng (.sys_clk(sys_clk), .rst(rst), .testStart(testStart),
    .testCode(testCode), .failCode(failCode), .failKind(failKind),
    .testDone(testDone), .testResult(testResult));
  // Compare and count
  task automatic check(input logic [CODE_W-1:0] seen, input logic [CODE_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Bounded wait on 0 ready, 1 halted, 2 error shown
  task automatic wait_hi(input int sel);
    int i;
    for (i = 0; i < 5000 &&
         (((sel == 0) ? readyLight : (sel == 1) ? halted : errorShow) !== 1'b1); i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 5000) begin
      check(8'h00, 8'h01);
      wrap_up();
    end
    #1;
  endtask : wait_hi
  // Reset with a new plan; expected codes go in the queue, ascending
  task automatic run(input logic [NSTEPS*SUBN_W-1:0] s, input logic [7:0] fc,
                     input logic [1:0] fk);
    logic done;
    done = 1'b0;
    expQ.delete();
    for (int g = 0; g < 10; g++) begin
      for (int k = 0; k < s[g*SUBN_W+:SUBN_W] && !done; k++) begin
        expQ.push_back(BASES[g] + CODE_W'(k));
        done = fk == RES_FATAL && (BASES[g] + CODE_W'(k)) == fc;
      end
    end
    @(posedge sys_clk);
    subCount <= s;
    failCode <= fc;
    failKind <= fk;
    rst      <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst      <= 1'b0;
    sawSignOn = 1'b0;
  endtask : run
  // Monitor: each start takes the oldest expected code
  always @(posedge sys_clk) begin
    if (signOn === 1'b1) begin
      sawSignOn = 1'b1;
    end
    if (lastCode !== 8'hFF) begin
      check(displayCode, lastCode);
    end
    lastCode = 8'hFF;
    if (testStart === 1'b1) begin
      if (expQ.size() == 0) begin
        check(8'h00, 8'h01);
      end else begin
        lastCode = expQ.pop_front();
        check(testCode, lastCode);
      end
    end
  end
  // Pass run, then nonfatal with a group absent, then fatal
  initial begin
    lastCode = 8'hFF;
    void'($urandom(92));
    for (int g = 0; g < 10; g++) begin
      sc[g*SUBN_W+:SUBN_W] = SUBN_W'($urandom_range(1, 3));
    end
    run(sc, 8'hFF, RES_PASS);
    wait_hi(0);
    check({sawSignOn, normalRun, errorShow}, 8'h06);
    check(8'(expQ.size()), 8'h00);
    sc[8*SUBN_W+:SUBN_W] = '0;
    run(sc, CODE_GPIB, RES_NONFATAL);
    wait_hi(2);
    check(errorCode, CODE_GPIB);
    check({errorFatal, readyLight}, 8'h00);
    for (cnt = 0; cnt < 5000 && errorShow === 1'b1; cnt++) begin
      @(posedge sys_clk);
      #1;
    end
    check(8'(cnt >= HOLD && cnt <= HOLD + 4), 8'h01);
    wait_hi(0);
    check(8'(expQ.size()), 8'h00);
    run(sc, CODE_CMOS, RES_FATAL);
    wait_hi(1);
    check({errorFatal, errorShow}, 8'h03);
    check(errorCode, CODE_CMOS);
    repeat (50) @(posedge sys_clk);
    #1;
    check({readyLight, normalRun, halted}, 8'h01);
    check(8'(expQ.size()), 8'h00);
    wrap_up();
  end
endmodule : test_power_on_confidence_test_sequencer
